//--- verilog/rsu_pkg.sv
`default_nettype none
package rsu_pkg;

  // clock and sweep limits
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned SWEEP_LONG_MS  = 250;
  localparam int unsigned SWEEP_SHORT_MS = 150;
  localparam int unsigned SWEEP_LONG_CYC  = SWEEP_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned SWEEP_SHORT_CYC = SWEEP_SHORT_MS * (CLK_HZ / 1000);

  // apb register map (byte addresses)
  localparam int unsigned APB_AW     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS = 8'h04;
  localparam logic [7:0]  OFF_RANGE  = 8'h08;

  // ctrl bits
  localparam int unsigned CTRL_WD_OFF    = 0;
  localparam int unsigned CTRL_FORCE_SW  = 1;
  localparam int unsigned CTRL_FAULT_CLR = 2;

  // status bits
  localparam int unsigned ST_HOLD     = 0;
  localparam int unsigned ST_MASTER   = 1;
  localparam int unsigned ST_DUAL     = 2;
  localparam int unsigned ST_INIT     = 3;
  localparam int unsigned ST_FAULT    = 4;
  localparam int unsigned ST_BK_ON    = 5;
  localparam int unsigned ST_TABLE    = 6;
  localparam int unsigned ST_REVERSE  = 7;
  localparam int unsigned ST_BLOCK    = 8;
  localparam int unsigned ST_RANGE_OK = 9;

  // range register fields
  localparam int unsigned RANGE_START_LSB = 0;
  localparam int unsigned RANGE_END_LSB   = 16;
  localparam int unsigned RANGE_W         = 16;

  // register block limits and table extents
  localparam logic [15:0] BLK_MIN       = 16'h0001;
  localparam logic [15:0] BLK_MAX       = 16'h1000;
  localparam logic [15:0] AUX_OUT_FIRST = 16'h0001;
  localparam logic [15:0] AUX_OUT_LAST  = 16'h0040;
  localparam logic [15:0] AUX_IN_FIRST  = 16'h0041;
  localparam logic [15:0] AUX_IN_LAST   = 16'h0080;
  localparam logic [15:0] FULL_INIT_REGS = 16'h1000;

  // jumper encoding: input high means position 2-3
  localparam logic JP_POS_23 = 1'b1;

  // synchronised pin vector layout
  localparam int unsigned IN_J_TABLE    = 0;
  localparam int unsigned IN_J_REVERSE  = 1;
  localparam int unsigned IN_J_BLOCK    = 2;
  localparam int unsigned IN_J_FULL     = 3;
  localparam int unsigned IN_J_FLAG     = 4;
  localparam int unsigned IN_J_SWEEP    = 5;
  localparam int unsigned IN_J_DUAL_M   = 6;
  localparam int unsigned IN_J_DUAL_A   = 7;
  localparam int unsigned IN_AUX_PRES   = 8;
  localparam int unsigned IN_SUPPLY_OK  = 9;
  localparam int unsigned IN_KEY_RUN    = 10;
  localparam int unsigned IN_KEY_PREF2  = 11;
  localparam int unsigned IN_CPU1_PWR   = 12;
  localparam int unsigned IN_CPU2_PWR   = 13;
  localparam int unsigned IN_CPU1_SWEEP = 14;
  localparam int unsigned IN_CPU2_SWEEP = 15;
  localparam int unsigned IN_MO_TABLE   = 16;
  localparam int unsigned IN_MO_REVERSE = 17;
  localparam int unsigned IN_MO_BLOCK   = 18;
  localparam int unsigned NIN           = 19;

  // transfer pulse layout
  localparam int unsigned X_AUX_IN  = 0;
  localparam int unsigned X_AUX_OUT = 1;
  localparam int unsigned X_TABLE   = 2;
  localparam int unsigned X_REVERSE = 3;
  localparam int unsigned X_BLOCK   = 4;
  localparam int unsigned X_FULL    = 5;
  localparam int unsigned NX        = 6;

  typedef struct packed {
    logic [NIN-1:0]     s1;
    logic [NIN-1:0]     s2;
    logic [NIN-1:0]     s3;
    logic [NIN-1:0]     stab;
    logic [NIN-1:0]     stab_d;
    logic               hold;
    logic               armed;
    logic               master;
    logic               init_pend;
    logic               fault_seen;
    logic               wd_off;
    logic               dual;
    logic               flag_1022;
    logic               flag_1024;
    logic [RANGE_W-1:0] blk_start;
    logic [RANGE_W-1:0] blk_end;
    logic [NX-1:0]      xfer;
    logic [31:0]        prdata;
    logic               pslverr;
  } rsu_main_t;

endpackage : rsu_pkg
`default_nettype wire

//--- verilog/rsu_sweep_if.sv
`default_nettype none
interface rsu_sweep_if;
  logic sweep_end;
  logic limit_long;
  logic run;
  logic fault;
  modport watch (input sweep_end, input limit_long, input run, output fault);
  modport ctl   (output sweep_end, output limit_long, output run, input fault);
endinterface : rsu_sweep_if
`default_nettype wire

//--- verilog/rsu_sweep_watch.sv
`default_nettype none
module rsu_sweep_watch
  import rsu_pkg::*;
#(
  parameter int unsigned LONG_CYC  = SWEEP_LONG_CYC,
  parameter int unsigned SHORT_CYC = SWEEP_SHORT_CYC
) (
  input  wire logic      mclk,
  input  wire logic      reset_n,
  rsu_sweep_if.watch     sw
);

  localparam int unsigned CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] LIM_L = CW'(LONG_CYC);
  localparam logic [CW-1:0] LIM_S = CW'(SHORT_CYC);
  localparam logic [CW-1:0] ONE   = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          fault;
  } rsu_watch_t;

  rsu_watch_t st_reg;
  rsu_watch_t st_next;
  logic [CW-1:0] limit;

  always_comb begin
    limit   = sw.limit_long ? LIM_L : LIM_S;
    st_next = st_reg;
    st_next.fault = 1'b0;
    // a sweep end or a stopped watch restarts the measurement
    if (!sw.run || sw.sweep_end) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt + ONE >= limit) begin
      st_next.fault = 1'b1;
      st_next.cnt   = '0;
    end else begin
      st_next.cnt = st_reg.cnt + ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sw.fault = st_reg.fault;

endmodule // rsu_sweep_watch
`default_nettype wire

//--- verilog/rsu_switch_unit.sv
// Implementation choices: register access over APB and the register addresses.
`default_nettype none
module rsu_switch_unit
  import rsu_pkg::*;
#(
  parameter int unsigned LONG_CYC  = SWEEP_LONG_CYC,
  parameter int unsigned SHORT_CYC = SWEEP_SHORT_CYC
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // jumpers, high = position 2-3
  input  wire logic              table_copy_select,
  input  wire logic              reverse_word_copy_select,
  input  wire logic              register_block_copy_select,
  input  wire logic              backup_full_init_select,
  input  wire logic              backup_flag_location_jumper,
  input  wire logic              sweep_limit_jumper,
  input  wire logic              dual_chain_select_main,
  input  wire logic              dual_chain_select_aux,
  // unit state pins
  input  wire logic              aux_modules_present,
  input  wire logic              main_supply_ok,
  input  wire logic              key_run,
  input  wire logic              key_prefer_cpu2,
  input  wire logic              cpu1_power_ok,
  input  wire logic              cpu2_power_ok,
  input  wire logic              cpu1_sweep_end,
  input  wire logic              cpu2_sweep_end,
  // master cpu outputs O1022..O1024
  input  wire logic              master_out_table,
  input  wire logic              master_out_reverse,
  input  wire logic              master_out_block,
  // results
  output logic                   io_from_cpu2,
  output logic                   hold_mode,
  output logic                   io_passthrough,
  output logic                   dual_chain,
  output logic                   backup_flag_i1022,
  output logic                   backup_flag_i1024,
  output logic                   xfer_aux_in,
  output logic                   xfer_aux_out,
  output logic                   xfer_table,
  output logic                   xfer_reverse,
  output logic                   xfer_block,
  output logic                   xfer_full_init,
  output logic [RANGE_W-1:0]     block_start,
  output logic [RANGE_W-1:0]     block_end,
  output logic                   sweep_fault
);

  rsu_main_t     st_reg;
  rsu_main_t     st_next;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] filt;
  rsu_sweep_if    swi ();

  assign pins[IN_J_TABLE]    = table_copy_select;
  assign pins[IN_J_REVERSE]  = reverse_word_copy_select;
  assign pins[IN_J_BLOCK]    = register_block_copy_select;
  assign pins[IN_J_FULL]     = backup_full_init_select;
  assign pins[IN_J_FLAG]     = backup_flag_location_jumper;
  assign pins[IN_J_SWEEP]    = sweep_limit_jumper;
  assign pins[IN_J_DUAL_M]   = dual_chain_select_main;
  assign pins[IN_J_DUAL_A]   = dual_chain_select_aux;
  assign pins[IN_AUX_PRES]   = aux_modules_present;
  assign pins[IN_SUPPLY_OK]  = main_supply_ok;
  assign pins[IN_KEY_RUN]    = key_run;
  assign pins[IN_KEY_PREF2]  = key_prefer_cpu2;
  assign pins[IN_CPU1_PWR]   = cpu1_power_ok;
  assign pins[IN_CPU2_PWR]   = cpu2_power_ok;
  assign pins[IN_CPU1_SWEEP] = cpu1_sweep_end;
  assign pins[IN_CPU2_SWEEP] = cpu2_sweep_end;
  assign pins[IN_MO_TABLE]   = master_out_table;
  assign pins[IN_MO_REVERSE] = master_out_reverse;
  assign pins[IN_MO_BLOCK]   = master_out_block;

  ////////////////////////////////////////////////////////////////////////////
  // pin filter: a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_filt
      assign filt[gi] = (st_reg.s2[gi] == st_reg.s3[gi]) ? st_reg.s3[gi] : st_reg.stab[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // decoded conditions: pin terms from filtered state, apb terms from the raw bus
  logic run_ok;
  logic mst_pwr;
  logic alt_pwr;
  logic sweep_edge;
  logic en_table;
  logic en_reverse;
  logic en_block;
  logic range_ok;
  logic do_switch;
  logic bk_rise;
  logic force_sw;
  logic fault_clr;
  logic wr_acc;
  logic rd_setup;

  always_comb begin
    run_ok     = st_reg.stab[IN_SUPPLY_OK] && st_reg.stab[IN_KEY_RUN];
    mst_pwr    = st_reg.master ? st_reg.stab[IN_CPU2_PWR] : st_reg.stab[IN_CPU1_PWR];
    alt_pwr    = st_reg.master ? st_reg.stab[IN_CPU1_PWR] : st_reg.stab[IN_CPU2_PWR];
    sweep_edge = st_reg.master
               ? (st_reg.stab[IN_CPU2_SWEEP] && !st_reg.stab_d[IN_CPU2_SWEEP])
               : (st_reg.stab[IN_CPU1_SWEEP] && !st_reg.stab_d[IN_CPU1_SWEEP]);
    en_table   = (st_reg.stab[IN_J_TABLE] == JP_POS_23) || st_reg.stab[IN_MO_TABLE];
    en_reverse = (st_reg.stab[IN_J_REVERSE] == JP_POS_23)
               || st_reg.stab[IN_MO_REVERSE];
    en_block   = (st_reg.stab[IN_J_BLOCK] == JP_POS_23) || st_reg.stab[IN_MO_BLOCK];
    range_ok   = (st_reg.blk_start >= BLK_MIN) && (st_reg.blk_end <= BLK_MAX)
               && (st_reg.blk_start <= st_reg.blk_end);
    wr_acc     = psel && penable && pwrite;
    rd_setup   = psel && !penable;
    force_sw   = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_FORCE_SW];
    fault_clr  = wr_acc && (paddr == OFF_CTRL) && pwdata[CTRL_FAULT_CLR];
    // switchover only from run, and only to a powered alternate
    do_switch  = !st_reg.hold && st_reg.armed && alt_pwr
               && (!mst_pwr || swi.fault || force_sw);
    // old master becomes backup on switch; or backup comes back on line
    bk_rise    = do_switch || (alt_pwr && !(st_reg.master
               ? st_reg.stab_d[IN_CPU1_PWR] : st_reg.stab_d[IN_CPU2_PWR]));
  end

  assign swi.sweep_end  = sweep_edge;
  assign swi.limit_long = (st_reg.stab[IN_J_SWEEP] != JP_POS_23);
  assign swi.run        = !st_reg.hold && st_reg.armed && !st_reg.wd_off;

  rsu_sweep_watch #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_watch (
    .mclk    (mclk),
    .reset_n (reset_n),
    .sw      (swi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next        = st_reg;
    st_next.s1     = pins;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    st_next.stab   = filt;
    st_next.stab_d = st_reg.stab;
    st_next.xfer   = '0;

    // hold follows supply and key; leaving it needs both restored
    st_next.hold = !run_ok;
    if (run_ok) begin
      st_next.armed = 1'b1;
    end

    // before first run the preferred master drives the I/O
    if (!st_reg.armed) begin
      st_next.master = st_reg.stab[IN_KEY_PREF2];
    end else if (do_switch) begin
      st_next.master = !st_reg.master;
    end

    st_next.dual = (st_reg.stab[IN_J_DUAL_M] == JP_POS_23)
                 || (st_reg.stab[IN_AUX_PRES] && st_reg.stab[IN_J_DUAL_A] == JP_POS_23);
    st_next.flag_1024 = alt_pwr && (st_reg.stab[IN_J_FLAG] != JP_POS_23);
    st_next.flag_1022 = alt_pwr && (st_reg.stab[IN_J_FLAG] == JP_POS_23);

    // per-sweep copies, suppressed entirely in hold and in the cycle hold rises
    if (sweep_edge && run_ok && !st_reg.hold && st_reg.armed && alt_pwr) begin
      st_next.xfer[X_AUX_IN]  = st_reg.stab[IN_AUX_PRES];
      st_next.xfer[X_AUX_OUT] = st_reg.stab[IN_AUX_PRES] && en_table;
      st_next.xfer[X_TABLE]   = en_table;
      st_next.xfer[X_REVERSE] = en_reverse;
      st_next.xfer[X_BLOCK]   = en_block && range_ok;
      st_next.xfer[X_FULL]    = st_reg.init_pend
                              && (st_reg.stab[IN_J_FULL] == JP_POS_23);
      st_next.init_pend       = 1'b0;
    end
    // a new backup arriving in the clearing cycle is kept
    if (bk_rise) begin
      st_next.init_pend = 1'b1;
    end

    // sticky fault, set wins over clear
    if (fault_clr) begin
      st_next.fault_seen = 1'b0;
    end
    if (swi.fault) begin
      st_next.fault_seen = 1'b1;
    end

    // apb write at access phase
    if (wr_acc && paddr == OFF_CTRL) begin
      st_next.wd_off = pwdata[CTRL_WD_OFF];
    end
    if (wr_acc && paddr == OFF_RANGE) begin
      st_next.blk_start = pwdata[RANGE_START_LSB +: RANGE_W];
      st_next.blk_end   = pwdata[RANGE_END_LSB +: RANGE_W];
    end

    // read data captured in setup so it leaves a flop
    if (rd_setup) begin
      st_next.prdata  = '0;
      st_next.pslverr = 1'b0;
      unique case (paddr)
        OFF_CTRL: begin
          st_next.prdata[CTRL_WD_OFF] = st_reg.wd_off;
        end
        OFF_STATUS: begin
          st_next.prdata[ST_HOLD]     = st_reg.hold;
          st_next.prdata[ST_MASTER]   = st_reg.master;
          st_next.prdata[ST_DUAL]     = st_reg.dual;
          st_next.prdata[ST_INIT]     = st_reg.init_pend;
          st_next.prdata[ST_FAULT]    = st_reg.fault_seen;
          st_next.prdata[ST_BK_ON]    = alt_pwr;
          st_next.prdata[ST_TABLE]    = en_table;
          st_next.prdata[ST_REVERSE]  = en_reverse;
          st_next.prdata[ST_BLOCK]    = en_block;
          st_next.prdata[ST_RANGE_OK] = range_ok;
        end
        OFF_RANGE: begin
          st_next.prdata[RANGE_START_LSB +: RANGE_W] = st_reg.blk_start;
          st_next.prdata[RANGE_END_LSB +: RANGE_W]   = st_reg.blk_end;
        end
        default: begin
          st_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata            = st_reg.prdata;
  assign pslverr           = st_reg.pslverr;
  assign pready            = 1'b1;
  assign io_from_cpu2      = st_reg.master;
  assign hold_mode         = st_reg.hold;
  // no traffic is inserted while held
  assign io_passthrough    = st_reg.hold;
  assign dual_chain        = st_reg.dual;
  assign backup_flag_i1022 = st_reg.flag_1022;
  assign backup_flag_i1024 = st_reg.flag_1024;
  assign xfer_aux_in       = st_reg.xfer[X_AUX_IN];
  assign xfer_aux_out      = st_reg.xfer[X_AUX_OUT];
  assign xfer_table        = st_reg.xfer[X_TABLE];
  assign xfer_reverse      = st_reg.xfer[X_REVERSE];
  assign xfer_block        = st_reg.xfer[X_BLOCK];
  assign xfer_full_init    = st_reg.xfer[X_FULL];
  assign block_start       = st_reg.blk_start;
  assign block_end         = st_reg.blk_end;
  assign sweep_fault       = st_reg.fault_seen;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_hold_on_loss: assert property (@(posedge mclk) disable iff (!reset_n)
    !st_reg.stab[IN_SUPPLY_OK] |=> hold_mode)
    else $error("supply loss did not force hold");

  chk_hold_no_xfer: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(st_reg.hold) |-> (st_reg.xfer == '0))
    else $error("transfer issued while held");

  chk_hold_no_switch: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_reg.hold && st_reg.armed) |=> $stable(io_from_cpu2))
    else $error("master changed while held");

  chk_pass_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    io_passthrough |-> !(xfer_aux_in || xfer_table || xfer_block || xfer_full_init))
    else $error("traffic inserted in pass-through");

  chk_pref_master: assert property (@(posedge mclk) disable iff (!reset_n)
    !st_reg.armed |=> io_from_cpu2 == $past(st_reg.stab[IN_KEY_PREF2]))
    else $error("preferred master not used");

  chk_switch_loss: assert property (@(posedge mclk) disable iff (!reset_n)
    (!st_reg.hold && st_reg.armed && !mst_pwr && alt_pwr) |=> $changed(io_from_cpu2))
    else $error("no switchover on master power loss");

  chk_dual_sel: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 dual_chain == $past(st_reg.stab[IN_J_DUAL_M]
      || (st_reg.stab[IN_AUX_PRES] && st_reg.stab[IN_J_DUAL_A])))
    else $error("chain mode wrong");

  chk_aux_in_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    (sweep_edge && run_ok && !st_reg.hold && st_reg.armed && alt_pwr
      && st_reg.stab[IN_AUX_PRES]) |=> xfer_aux_in)
    else $error("aux input table not copied");

  chk_aux_absent: assert property (@(posedge mclk) disable iff (!reset_n)
    (xfer_aux_in || xfer_aux_out) |-> $past(st_reg.stab[IN_AUX_PRES]))
    else $error("aux copy without aux modules");

  chk_table_en: assert property (@(posedge mclk) disable iff (!reset_n)
    (xfer_table || xfer_aux_out) |-> $past(en_table))
    else $error("table copy while disabled");

  chk_block_range: assert property (@(posedge mclk) disable iff (!reset_n)
    xfer_block |-> ($past(range_ok) && $past(en_block)))
    else $error("block copy with bad range");

  chk_flag_loc: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(alt_pwr) |-> (backup_flag_i1022 == $past(st_reg.stab[IN_J_FLAG]))
      && (backup_flag_i1024 != $past(st_reg.stab[IN_J_FLAG])))
    else $error("backup flag at wrong input");

  cov_switch: cover property (@(posedge mclk) disable iff (!reset_n)
    $changed(io_from_cpu2) && st_reg.armed);
  cov_full_init: cover property (@(posedge mclk) disable iff (!reset_n) xfer_full_init);
  cov_block: cover property (@(posedge mclk) disable iff (!reset_n) xfer_block);
  cov_hold: cover property (@(posedge mclk) disable iff (!reset_n) $rose(hold_mode));

endmodule // rsu_switch_unit
`default_nettype wire

//--- tb/rsu_cpu_pair.sv
`default_nettype none
module rsu_cpu_pair (
  input  wire logic mclk,
  input  wire logic sweep_req,
  input  wire logic from_cpu2,
  output logic      cpu1_sweep_end,
  output logic      cpu2_sweep_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg = 4'h0;
  // only the master ends sweeps; 4 high then a long low gap so the unit's filter agrees
  always_ff @(posedge mclk) begin
    if (sweep_req || cnt_reg != 4'h0) cnt_reg <= cnt_reg + 4'h1;
  end
  assign cpu1_sweep_end = !from_cpu2 && cnt_reg inside {[4'h1:4'h4]};
  assign cpu2_sweep_end = from_cpu2 && cnt_reg inside {[4'h1:4'h4]};
endmodule // rsu_cpu_pair
`default_nettype wire

//--- tb/rsu_switch_unit_test.sv
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rsu_switch_unit_test import rsu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, reset_n = 1'b0, req = 1'b0, er;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, jp = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0]  mo = 3'h0;
  logic        aux = 1'b0, sup = 1'b1, krun = 1'b1, kp2 = 1'b1, p1 = 1'b1, p2 = 1'b1;
  logic [5:0]  seen;
  wire  [31:0] prdata;
  wire  [15:0] be, bs;
  wire  [5:0]  xf;
  wire         pready, pslverr, io2, hold, pass, dual, f22, f24, sf, c1s, c2s;
  int          fail_count = 0, checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  rsu_switch_unit #(.LONG_CYC(200), .SHORT_CYC(120)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .table_copy_select(jp[0]), .reverse_word_copy_select(jp[1]),
    .register_block_copy_select(jp[2]), .backup_full_init_select(jp[3]),
    .backup_flag_location_jumper(jp[4]), .sweep_limit_jumper(jp[5]),
    .dual_chain_select_main(jp[6]), .dual_chain_select_aux(jp[7]),
    .aux_modules_present(aux), .main_supply_ok(sup), .key_run(krun), .key_prefer_cpu2(kp2),
    .cpu1_power_ok(p1), .cpu2_power_ok(p2), .cpu1_sweep_end(c1s), .cpu2_sweep_end(c2s),
    .master_out_table(mo[0]), .master_out_reverse(mo[1]), .master_out_block(mo[2]),
    .io_from_cpu2(io2), .hold_mode(hold), .io_passthrough(pass), .dual_chain(dual),
    .backup_flag_i1022(f22), .backup_flag_i1024(f24), .xfer_aux_in(xf[0]),
    .xfer_aux_out(xf[1]), .xfer_table(xf[2]), .xfer_reverse(xf[3]), .xfer_block(xf[4]),
    .xfer_full_init(xf[5]), .block_start(bs), .block_end(be), .sweep_fault(sf));
  rsu_cpu_pair cpus_u (.mclk(mclk), .sweep_req(req), .from_cpu2(io2),
    .cpu1_sweep_end(c1s), .cpu2_sweep_end(c2s));
  initial forever #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // one idle cycle so a following call never re-drives psel in this time step
    @(posedge mclk);
  endtask
  // pulses last one cycle, so collect every edge rather than look once
  task automatic sweep(input logic [5:0] e);
    seen = 6'h00; req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    repeat (18) begin @(posedge mclk); seen = seen | xf; end
    `CHK("xfer", e, seen)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("slverr", 1'b1, er)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("st_master", 1'b1, rd[ST_MASTER])
    `CHK("io2", 1'b1, io2)
    `CHK("hold", 1'b0, hold)
    $display("t_start done");
  endtask
  task automatic t_copy;
    aux <= 1'b1; wt(8);
    sweep(6'h01);
    apb(1'b1, OFF_RANGE, 32'h0004_0005); mo <= 3'h7; wt(8);
    sweep(6'h0f);
    apb(1'b1, OFF_RANGE, {BLK_MAX, BLK_MIN});
    sweep(6'h1f);
    `CHK("blk_end", BLK_MAX, be)
    `CHK("blk_start", BLK_MIN, bs)
    mo <= 3'h0; jp[2:0] <= 3'h7; wt(8);
    sweep(6'h1f);
    aux <= 1'b0; wt(8);
    sweep(6'h1c);
    $display("t_copy done");
  endtask
  task automatic t_cfg;
    jp <= 8'h00; wt(8);
    `CHK("f24", 1'b1, f24)
    jp[4] <= 1'b1; wt(8);
    `CHK("f22", 2'b01, {f24, f22})
    jp[6] <= 1'b1; wt(8);
    `CHK("dual", 1'b1, dual)
    jp[6] <= 1'b0; jp[7] <= 1'b1; aux <= 1'b1; wt(8);
    `CHK("dual", 1'b1, dual)
    jp[7] <= 1'b0; aux <= 1'b0; wt(8);
    `CHK("dual", 1'b0, dual)
    $display("t_cfg done");
  endtask
  task automatic t_switch;
    jp[3] <= 1'b1; p2 <= 1'b0; wt(8);
    `CHK("io2", 1'b0, io2)
    sweep(6'h00);
    p2 <= 1'b1; wt(8);
    sweep(6'h20);
    jp[3] <= 1'b0; p2 <= 1'b0; wt(8); p2 <= 1'b1; wt(8);
    sweep(6'h00);
    $display("t_switch done");
  endtask
  task automatic t_hold;
    sup <= 1'b0; wt(8);
    `CHK("hold", 2'b11, {hold, pass})
    aux <= 1'b1; mo <= 3'h7; wt(8);
    sweep(6'h00);
    p1 <= 1'b0; wt(8);
    `CHK("io2", 1'b0, io2)
    sup <= 1'b1; krun <= 1'b0; wt(8);
    `CHK("hold", 1'b1, hold)
    krun <= 1'b1; wt(8);
    `CHK("io2", 2'b01, {hold, io2})
    p1 <= 1'b1; aux <= 1'b0; mo <= 3'h0; wt(8);
    $display("t_hold done");
  endtask
  // 120-cycle limit vs 200: the second look falls between the two
  task automatic t_watch;
    jp[5] <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0);
    sweep(6'h00);
    wt(90);
    `CHK("fault", 1'b0, sf)
    wt(60);
    `CHK("fault", 2'b10, {sf, io2})
    // stop the watch and clear the sticky flag, then force a switch back
    apb(1'b1, OFF_CTRL, 32'h5);
    `CHK("fault", 1'b0, sf)
    apb(1'b1, OFF_CTRL, 32'h3);
    `CHK("io2", 1'b1, io2)
    $display("t_watch done");
  endtask
  initial begin
    wt(20); reset_n <= 1'b1; wt(10);
    apb(1'b1, OFF_CTRL, 32'h1);
    t_start; t_copy; t_cfg; t_switch; t_hold; t_watch;
    close_out;
  end
  initial begin
    wt(5000); fail_count++;
    close_out;
  end
endmodule // rsu_switch_unit_test
`default_nettype wire
